// File: rtl/led_cluster_pkg.sv
// Constants for the LED sink cluster PWM and boost controller
package led_cluster_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  // Register offsets
  localparam logic [4:0] MAIN_LEVEL_OFS = 5'h00;
  localparam logic [4:0] STRING2_LEVEL_OFS = 5'h01;
  localparam logic [4:0] STRING3_LEVEL_OFS = 5'h02;
  localparam logic [4:0] STRING4_LEVEL_OFS = 5'h03;
  localparam logic [4:0] SCALE_TRIM_OFS = 5'h04;
  localparam logic [4:0] MODE_CTRL_OFS = 5'h05;
  localparam logic [4:0] MAIN_BRT_OFS = 5'h06;
  localparam logic [4:0] STRING2_BRT_OFS = 5'h07;
  localparam logic [4:0] STRING3_BRT_OFS = 5'h08;
  localparam logic [4:0] STRING4_BRT_OFS = 5'h09;
  localparam logic [4:0] BOOST_CTRL_OFS = 5'h0a;
  localparam logic [4:0] THRESH_OFS = 5'h0b;
  localparam logic [4:0] STATUS_OFS = 5'h0c;
  localparam logic [4:0] TARGET0_OFS = 5'h10;
  localparam logic [4:0] TARGET1_OFS = 5'h11;
  localparam logic [4:0] TARGET2_OFS = 5'h12;
  localparam logic [4:0] TARGET3_OFS = 5'h13;
  localparam logic [4:0] BOOST_SET_OFS = 5'h14;
  localparam logic [4:0] RSET_OFS = 5'h15;
  // MODE_CTRL fields
  localparam int CLUSTER_LSB = 0;
  localparam int EXT_REF_BIT = 4;
  localparam int FAULT_EN_BIT = 5;
  localparam int PWM_RATE_LSB = 6;
  localparam int DISP_RES_LSB = 8;
  // BOOST_CTRL fields
  localparam int INIT_V_LSB = 0;
  localparam int FREQ_SEL_LSB = 6;
  localparam int ADAPT_BIT = 9;
  localparam int SPREAD_BIT = 10;
  localparam int BOOST_EN_BIT = 11;
  localparam int STEP_MV = 125;
  // Reset values
  localparam logic [15:0] MODE_CTRL_RST = 16'h0020;
  localparam logic [15:0] BOOST_CTRL_RST = 16'h0800;
  localparam logic [15:0] RSET_RST = 16'h5dc0;
  localparam logic [15:0] TRIM_RST = 16'h7777;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int SPREAD_MOD_HZ = 1875;
  localparam int SPREAD_PCT = 3;
  localparam int SYNC_LOSS_NS = 20_000;
  localparam int SYNC_LOSS_CYC = SYNC_LOSS_NS / 100;
  localparam int SPREAD_HALF_CYC = CLK_HZ / (2 * SPREAD_MOD_HZ);
  localparam int RAMP_NS = 1000;
  localparam int RAMP_CYC = RAMP_NS / 100;
  localparam int FREQ_KHZ [8] = '{100, 200, 300, 400, 600, 1000, 1600, 2200};
  typedef enum logic [1:0] {
    BST_OFF = 2'b00,
    BST_RAMP = 2'b01,
    BST_RUN = 2'b10
  } boost_state_t;
endpackage

// File: rtl/led_cluster_ctrl.sv
// LED sink cluster PWM, current target and boost setpoint controller
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Range code picks full scale: 25,30,50,60,80,100,120,150 mA.
// - External reference: 3000*1.2V/R times level/4095, scale/150, trim.
// - Internal reference: level/4095 times full scale times trim.
// - Outputs two to four in cluster use 8-bit level over 255.
// - Four-bit trim per output, factor (correction+1000)/1000, 0111 is neutral.
// - Main level and range load from stored copies at start-up.
// - Reset clears string two and three cluster levels.
// - Cluster strings use plain register PWM, pin input and dimming extras ignored.
// - Brightness per string; output one cluster uses 13 MSBs.
// - All cluster: 13-bit PWM at clock/8192; the rate field is stored but unused.
// - Any display string: cluster strings follow display frequency and resolution.
// - Cluster fault when headroom above high or below low threshold.
// - Adaptive boost follows only display string headroom.
// - All cluster: boost held at initial voltage setting.
// - Cluster fault enable low suppresses cluster fault detection.
// - Cluster strings skip thermal derating, sensor limiting, hot shutdown.
// - Boost start ramps to initial setting, then adapts if enabled.
// - Adaptive steps are 125 mV based on headroom.
// - Three-bit field selects internal boost rate 100 kHz to 2.2 MHz.
// - External clock drives boost when present, else internal rate.
// - Spread spectrum swings rate 2 percent at 1.875 kHz, only at the 100 kHz setting.
module led_cluster_ctrl #(
  parameter int SYNC_LOSS = led_cluster_pkg::SYNC_LOSS_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [led_cluster_pkg::ADDR_W-1:0] addr_i,
  input wire logic [led_cluster_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [led_cluster_pkg::DATA_W-1:0] rdata_o,
  input wire logic [11:0] stored_main_level_i,
  input wire logic [2:0] stored_range_i,
  input wire logic pwm_pin_i,
  input wire logic [3:0] head_high_i,
  input wire logic [3:0] head_low_i,
  input wire logic [3:0] derate_i,
  input wire logic sync_clk_i,
  output logic [3:0] sink_on_o,
  output logic [3:0] cluster_fault_o,
  output logic [5:0] boost_setpoint_o,
  output logic boost_clk_o
);
  import led_cluster_pkg::*;

  // Parameter checks
  if (SYNC_LOSS < 2 || SYNC_LOSS > 65535) begin : g_loss_chk
    $error("SYNC_LOSS out of range");
  end
  if (RAMP_CYC < 1 || RAMP_CYC > 16 || SPREAD_HALF_CYC > 8192) begin : g_timing_chk
    $error("timing constants do not fit the counters");
  end

  logic [11:0] main_level_code_ff;
  logic [7:0] string_level_code_ff [1:3];
  logic [2:0] full_scale_range_sel_ff;
  logic [15:0] per_output_trim_ff;
  logic [15:0] mode_ff;
  logic [15:0] brt_ff [0:3];
  logic [15:0] boost_ctrl_ff;
  logic [15:0] rset_ff;
  logic [15:0] rdata_ff;
  logic started_ff;

  // Full scale current in mA
  function automatic logic [7:0] full_scale(input logic [2:0] sel);
    case (sel)
      3'h0: full_scale = 8'd25;
      3'h1: full_scale = 8'd30;
      3'h2: full_scale = 8'd50;
      3'h3: full_scale = 8'd60;
      3'h4: full_scale = 8'd80;
      3'h5: full_scale = 8'd100;
      3'h6: full_scale = 8'd120;
      default: full_scale = 8'd150;
    endcase
  endfunction

  // Trim correction in tenths of a percent
  function automatic logic signed [7:0] trim_tenths(input logic [3:0] code);
    case (code)
      4'h0: trim_tenths = 8'sd65;
      4'h1: trim_tenths = 8'sd56;
      4'h2: trim_tenths = 8'sd47;
      4'h3: trim_tenths = 8'sd37;
      4'h4: trim_tenths = 8'sd28;
      4'h5: trim_tenths = 8'sd19;
      4'h6: trim_tenths = 8'sd9;
      4'h7: trim_tenths = 8'sd0;
      4'h8: trim_tenths = -8'sd9;
      4'h9: trim_tenths = -8'sd19;
      4'ha: trim_tenths = -8'sd28;
      4'hb: trim_tenths = -8'sd37;
      4'hc: trim_tenths = -8'sd47;
      4'hd: trim_tenths = -8'sd56;
      4'he: trim_tenths = -8'sd65;
      default: trim_tenths = -8'sd74;
    endcase
  endfunction

  // Sink target in uA from level fraction, scale and trim
  function automatic logic [15:0] target_ua(input logic [11:0] lvl, input logic [11:0] lmax,
      input logic [2:0] sel, input logic [3:0] trim, input logic ext,
      input logic [15:0] rset);
    logic [63:0] num;
    logic [63:0] den;
    logic [63:0] fs;
    num = 64'd0;
    den = 64'd1;
    fs = {56'd0, full_scale(sel)};
    if (ext) begin
      num = 64'd3600000000 * {52'd0, lvl} * fs;
      den = {48'd0, rset} * {52'd0, lmax} * 64'd150;
    end else begin
      num = 64'd1000 * {52'd0, lvl} * fs;
      den = {52'd0, lmax};
    end
    num = num * 64'(1000 + 64'(signed'(trim_tenths(trim))));
    den = den * 64'd1000;
    if (den == 64'd0) begin
      target_ua = 16'hffff;
    end else begin
      target_ua = 16'((num / den) > 64'hffff ? 64'hffff : (num / den));
    end
  endfunction

  logic [3:0] cluster;
  logic all_cluster;
  logic [15:0] target [0:3];
  assign cluster = mode_ff[CLUSTER_LSB+:4];
  assign all_cluster = &cluster;

  always_comb begin
    target[0] = target_ua(main_level_code_ff, 12'd4095, full_scale_range_sel_ff,
        per_output_trim_ff[3:0], mode_ff[EXT_REF_BIT], rset_ff);
    for (int i = 1; i < 4; i++) begin
      target[i] = cluster[i] ?
          target_ua({4'h0, string_level_code_ff[i]}, 12'd255, full_scale_range_sel_ff,
          per_output_trim_ff[4*i+:4], mode_ff[EXT_REF_BIT], rset_ff) :
          target_ua(main_level_code_ff, 12'd4095, full_scale_range_sel_ff,
          per_output_trim_ff[4*i+:4], mode_ff[EXT_REF_BIT], rset_ff);
    end
  end

  // Register writes and start-up load
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      main_level_code_ff <= 12'h000;
      full_scale_range_sel_ff <= 3'h7;
      string_level_code_ff[1] <= 8'h00;
      string_level_code_ff[2] <= 8'h00;
      string_level_code_ff[3] <= 8'h00;
      per_output_trim_ff <= TRIM_RST;
      mode_ff <= MODE_CTRL_RST;
      boost_ctrl_ff <= BOOST_CTRL_RST;
      rset_ff <= RSET_RST;
      started_ff <= 1'b0;
      for (int i = 0; i < 4; i++) brt_ff[i] <= 16'h0000;
    end else if (!started_ff) begin
      started_ff <= 1'b1;
      main_level_code_ff <= stored_main_level_i;
      full_scale_range_sel_ff <= stored_range_i;
    end else if (wr_i) begin
      case (addr_i)
        MAIN_LEVEL_OFS: main_level_code_ff <= wdata_i[11:0];
        STRING2_LEVEL_OFS: string_level_code_ff[1] <= wdata_i[7:0];
        STRING3_LEVEL_OFS: string_level_code_ff[2] <= wdata_i[7:0];
        STRING4_LEVEL_OFS: string_level_code_ff[3] <= wdata_i[7:0];
        SCALE_TRIM_OFS: full_scale_range_sel_ff <= wdata_i[2:0];
        MODE_CTRL_OFS: mode_ff <= wdata_i & 16'h03ff;
        MAIN_BRT_OFS: brt_ff[0] <= wdata_i;
        STRING2_BRT_OFS: brt_ff[1] <= {3'h0, wdata_i[12:0]};
        STRING3_BRT_OFS: brt_ff[2] <= {3'h0, wdata_i[12:0]};
        STRING4_BRT_OFS: brt_ff[3] <= {3'h0, wdata_i[12:0]};
        BOOST_CTRL_OFS: boost_ctrl_ff <= wdata_i & 16'h0fff;
        THRESH_OFS: per_output_trim_ff <= wdata_i;
        RSET_OFS: rset_ff <= wdata_i;
        default: ;
      endcase
    end
  end

  // Pin synchronisers
  logic pwm_s1_ff, pwm_s2_ff, sync_s1_ff, sync_s2_ff, sync_s3_ff;
  logic [3:0] hh_s1_ff, hh_s2_ff, hl_s1_ff, hl_s2_ff, dr_s1_ff, dr_s2_ff;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      {pwm_s1_ff, pwm_s2_ff, sync_s1_ff, sync_s2_ff, sync_s3_ff} <= 5'h00;
      {hh_s1_ff, hh_s2_ff, hl_s1_ff, hl_s2_ff, dr_s1_ff, dr_s2_ff} <= 24'h000000;
    end else begin
      pwm_s1_ff <= pwm_pin_i;
      pwm_s2_ff <= pwm_s1_ff;
      sync_s1_ff <= sync_clk_i;
      sync_s2_ff <= sync_s1_ff;
      sync_s3_ff <= sync_s2_ff;
      hh_s1_ff <= head_high_i;
      hh_s2_ff <= hh_s1_ff;
      hl_s1_ff <= head_low_i;
      hl_s2_ff <= hl_s1_ff;
      dr_s1_ff <= derate_i;
      dr_s2_ff <= dr_s1_ff;
    end
  end

  // PWM counter: 13 bits when all cluster, else display resolution
  logic [12:0] pwm_cnt_ff;
  logic [3:0] res_bits;
  logic [12:0] pwm_mask;
  always_comb begin
    res_bits = all_cluster ? 4'd13 : 4'd10 + {2'h0, mode_ff[DISP_RES_LSB+:2]};
    if (res_bits > 4'd13) res_bits = 4'd13;
    pwm_mask = 13'h1fff >> (4'd13 - res_bits);
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pwm_cnt_ff <= 13'h0000;
    end else begin
      pwm_cnt_ff <= (pwm_cnt_ff + 13'h0001) & pwm_mask;
    end
  end

  logic [3:0] nxt_sink_on;
  always_comb begin
    logic [12:0] duty;
    duty = 13'h0000;
    for (int i = 0; i < 4; i++) begin
      duty = (i == 0) ? brt_ff[0][15:3] : brt_ff[i][12:0];
      duty = duty >> (4'd13 - res_bits);
      if (cluster[i]) begin
        nxt_sink_on[i] = duty > pwm_cnt_ff;
      end else begin
        nxt_sink_on[i] = duty > pwm_cnt_ff && pwm_s2_ff && !dr_s2_ff[i];
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sink_on_o <= 4'h0;
    end else begin
      sink_on_o <= nxt_sink_on;
    end
  end

  // Cluster headroom faults, sticky until status read
  logic status_rd;
  assign status_rd = rd_i && addr_i == STATUS_OFS;
  always_ff @(posedge clock_i) begin
    if (rst_i) cluster_fault_o <= 4'h0;
    else if (!mode_ff[FAULT_EN_BIT]) cluster_fault_o <= 4'h0;
    else cluster_fault_o <= (status_rd ? 4'h0 : cluster_fault_o)
        | (cluster & (hh_s2_ff | hl_s2_ff));
  end

  // Boost setpoint sequencing
  boost_state_t bst_ff;
  logic [3:0] ramp_cnt_ff;
  logic [5:0] init_v;
  logic [3:0] disp;
  assign init_v = boost_ctrl_ff[INIT_V_LSB+:6];
  assign disp = ~cluster;
  always_ff @(posedge clock_i) begin
    if (rst_i || !boost_ctrl_ff[BOOST_EN_BIT]) begin
      bst_ff <= BST_OFF;
      boost_setpoint_o <= 6'h00;
      ramp_cnt_ff <= 4'h0;
    end else begin
      case (bst_ff)
        BST_OFF: bst_ff <= BST_RAMP;
        BST_RAMP: begin
          ramp_cnt_ff <= (ramp_cnt_ff == 4'(RAMP_CYC - 1)) ? 4'h0 : ramp_cnt_ff + 4'h1;
          if (boost_setpoint_o == init_v) bst_ff <= BST_RUN;
          else if (ramp_cnt_ff == 4'(RAMP_CYC - 1))
            boost_setpoint_o <= boost_setpoint_o < init_v ? boost_setpoint_o + 6'h01
                : boost_setpoint_o - 6'h01;
        end
        BST_RUN: begin
          if (all_cluster || !boost_ctrl_ff[ADAPT_BIT]) begin
            boost_setpoint_o <= init_v;
          end else if (|(disp & hl_s2_ff) && boost_setpoint_o != 6'h3f) begin
            boost_setpoint_o <= boost_setpoint_o + 6'h01;
          end else if ((disp & hh_s2_ff) == disp && boost_setpoint_o != 6'h00) begin
            boost_setpoint_o <= boost_setpoint_o - 6'h01;
          end
        end
        default: bst_ff <= BST_OFF;
      endcase
    end
  end

  // Boost clock: internal divider with spread, or external sync
  logic [7:0] half_per;
  logic [7:0] spread_delta;
  logic [7:0] div_cnt_ff;
  logic [12:0] mod_cnt_ff;
  logic mod_dir_ff;
  logic [15:0] loss_cnt_ff;
  logic ext_ok;
  assign ext_ok = loss_cnt_ff < 16'(SYNC_LOSS);
  always_comb begin
    half_per = 8'(CLK_HZ / 2000 / FREQ_KHZ[boost_ctrl_ff[FREQ_SEL_LSB+:3]]);
    if (half_per == 8'h00) half_per = 8'h01;
    spread_delta = 8'((16'(half_per) * 16'(SPREAD_PCT)) / 16'd100);
    if (boost_ctrl_ff[SPREAD_BIT]) begin
      half_per = mod_dir_ff ? half_per + spread_delta : half_per - spread_delta;
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      div_cnt_ff <= 8'h00;
      mod_cnt_ff <= 13'h0000;
      mod_dir_ff <= 1'b0;
      loss_cnt_ff <= 16'(SYNC_LOSS);
      boost_clk_o <= 1'b0;
    end else begin
      if (mod_cnt_ff == 13'(SPREAD_HALF_CYC - 1)) begin
        mod_cnt_ff <= 13'h0000;
        mod_dir_ff <= ~mod_dir_ff;
      end else begin
        mod_cnt_ff <= mod_cnt_ff + 13'h0001;
      end
      if (sync_s2_ff != sync_s3_ff) loss_cnt_ff <= 16'h0000;
      else if (loss_cnt_ff < 16'(SYNC_LOSS)) loss_cnt_ff <= loss_cnt_ff + 16'h0001;
      if (ext_ok) begin
        // Follow sync edges only, so the hand-over leaves no runt phase
        if (sync_s2_ff != sync_s3_ff) begin
          boost_clk_o <= sync_s2_ff;
        end
        div_cnt_ff <= 8'h00;
      end else if (div_cnt_ff >= half_per - 8'h01) begin
        div_cnt_ff <= 8'h00;
        boost_clk_o <= ~boost_clk_o;
      end else begin
        div_cnt_ff <= div_cnt_ff + 8'h01;
      end
    end
  end

  // Register reads
  always_ff @(posedge clock_i) begin
    if (rst_i) rdata_ff <= 16'h0000;
    else if (rd_i) begin
      case (addr_i)
        MAIN_LEVEL_OFS: rdata_ff <= {4'h0, main_level_code_ff};
        STRING2_LEVEL_OFS: rdata_ff <= {8'h00, string_level_code_ff[1]};
        STRING3_LEVEL_OFS: rdata_ff <= {8'h00, string_level_code_ff[2]};
        STRING4_LEVEL_OFS: rdata_ff <= {8'h00, string_level_code_ff[3]};
        SCALE_TRIM_OFS: rdata_ff <= {13'h0000, full_scale_range_sel_ff};
        MODE_CTRL_OFS: rdata_ff <= mode_ff;
        MAIN_BRT_OFS: rdata_ff <= brt_ff[0];
        STRING2_BRT_OFS: rdata_ff <= brt_ff[1];
        STRING3_BRT_OFS: rdata_ff <= brt_ff[2];
        STRING4_BRT_OFS: rdata_ff <= brt_ff[3];
        BOOST_CTRL_OFS: rdata_ff <= boost_ctrl_ff;
        THRESH_OFS: rdata_ff <= per_output_trim_ff;
        STATUS_OFS: rdata_ff <= {8'h00, ext_ok, bst_ff, 1'b0, cluster_fault_o};
        TARGET0_OFS: rdata_ff <= target[0];
        TARGET1_OFS: rdata_ff <= target[1];
        TARGET2_OFS: rdata_ff <= target[2];
        TARGET3_OFS: rdata_ff <= target[3];
        BOOST_SET_OFS: rdata_ff <= {10'h000, boost_setpoint_o};
        RSET_OFS: rdata_ff <= rset_ff;
        default: rdata_ff <= 16'h0000;
      endcase
    end else begin
      rdata_ff <= 16'h0000;
    end
  end
  assign rdata_o = rdata_ff;
endmodule

// File: sim/led_cluster_monitor.sv
// Port checker for the LED cluster controller
`timescale 1ns/1ps
module led_cluster_monitor
  import led_cluster_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [led_cluster_pkg::ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [led_cluster_pkg::DATA_W-1:0] rdata_o,
  input wire logic [3:0] head_high_i,
  input wire logic [3:0] head_low_i,
  input wire logic [3:0] sink_on_o,
  input wire logic [3:0] cluster_fault_o,
  input wire logic [5:0] boost_setpoint_o,
  input wire logic boost_clk_o
);
  logic [3:0] head_any;
  assign head_any = head_high_i | head_low_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence unmapped_rd;
    rd_i && (addr_i > RSET_OFS || addr_i inside {[5'h0d:5'h0f]});
  endsequence
  sequence fault_rise;
    (cluster_fault_o & ~$past(cluster_fault_o)) != 4'h0;
  endsequence
  rdata_only_a:
    assert property (rdata_o != 16'h0 |-> $past(rd_i)) else $error("read data without read");
  write_quiet_a:
    assert property (wr_i |=> rdata_o == 16'h0) else $error("read data after write");
  unmapped_zero_a:
    assert property (unmapped_rd |=> rdata_o == 16'h0) else $error("unmapped read not zero");
  reset_quiet_a:
    assert property ($past(rst_i) |-> {sink_on_o, cluster_fault_o, boost_setpoint_o} == 14'h0
      && rdata_o == 16'h0) else $error("outputs busy after reset");
  fault_cause_a:
    assert property (fault_rise |-> ((cluster_fault_o & ~$past(cluster_fault_o))
      & ~($past(head_any, 2) | $past(head_any, 3) | $past(head_any, 4))) == 4'h0)
      else $error("fault without headroom cause");
  fault_clear_a:
    assert property ((|($past(cluster_fault_o) & ~cluster_fault_o)) |-> $past(wr_i)
      || $past(wr_i, 2) || $past(rd_i) || $past(rd_i, 2)) else $error("fault dropped alone");
  boost_step_a:
    assert property ($changed(boost_setpoint_o) && boost_setpoint_o != 6'h0 |->
      boost_setpoint_o == $past(boost_setpoint_o) + 6'h1
      || boost_setpoint_o == $past(boost_setpoint_o) - 6'h1) else $error("setpoint jumped");
  boost_clk_slow_a:
    assert property ($changed(boost_clk_o) |=> $stable(boost_clk_o))
      else $error("boost clock phase too short");
endmodule

// File: sim/led_strings_model.sv
// Model of the LED strings and the external boost clock source
`timescale 1ns/1ps
module led_strings_model (
  input wire logic clock_i,
  input wire logic [3:0] low_req_i,
  input wire logic [3:0] high_req_i,
  input wire logic [15:0] sync_half_i,
  output logic [3:0] head_high_o,
  output logic [3:0] head_low_o,
  output logic sync_clk_o
);
  // Headroom comparators follow the commanded string state
  always_ff @(posedge clock_i) begin
    head_low_o <= low_req_i;
    head_high_o <= high_req_i;
  end
  // Source stands low when off, runs only at the commanded rate
  initial begin
    sync_clk_o = 1'b0;
    #13;
    forever begin
      if (sync_half_i == 16'h0) begin
        sync_clk_o = 1'b0;
        #100;
      end else begin
        #(sync_half_i) sync_clk_o = ~sync_clk_o;
      end
    end
  end
endmodule

// File: sim/tb_led_cluster_ctrl.sv
// Self-checking bench for the LED cluster controller
`timescale 1ns/1ps
`define CHK(e, a) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("unexpected at %0t: exp %h got %h", $time, e, a); end end
module tb_led_cluster_ctrl;
  import led_cluster_pkg::*;
  logic clock_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, pwm_pin_i = 0, rd_seen = 0;
  logic sync_clk_i, boost_clk_o;
  logic [4:0] addr_i = 0;
  logic [15:0] wdata_i = 0, sync_half = 0, got_v, rdata_o;
  logic [11:0] stored_main_level_i = 0;
  logic [2:0] stored_range_i = 0;
  logic [3:0] derate_i = 0, low_req = 0, high_req = 0;
  logic [3:0] head_high_i, head_low_i, sink_on_o, cluster_fault_o;
  logic [5:0] boost_setpoint_o;
  logic [15:0] exp_q[$];
  int fails = 0, compares = 0, per, lo, hi;
  int hc[4];
  event got_e;
  localparam int FS_MA [8] = '{25, 30, 50, 60, 80, 100, 120, 150};
  led_cluster_ctrl #(.SYNC_LOSS(8)) dut_u (.clock_i(clock_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .stored_main_level_i(stored_main_level_i), .stored_range_i(stored_range_i),
    .pwm_pin_i(pwm_pin_i), .head_high_i(head_high_i), .head_low_i(head_low_i),
    .derate_i(derate_i), .sync_clk_i(sync_clk_i), .sink_on_o(sink_on_o),
    .cluster_fault_o(cluster_fault_o), .boost_setpoint_o(boost_setpoint_o),
    .boost_clk_o(boost_clk_o));
  led_strings_model part_u (.clock_i(clock_i), .low_req_i(low_req), .high_req_i(high_req),
    .sync_half_i(sync_half), .head_high_o(head_high_i), .head_low_o(head_low_i),
    .sync_clk_o(sync_clk_i));
  initial forever #50 clock_i = ~clock_i;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clock_i);
    exp_q.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask
  task automatic post(input logic [15:0] e, input logic [15:0] a);
    @(posedge clock_i);
    exp_q.push_back(e);
    got_v = a;
    ->got_e;
  endtask
  task automatic take(input logic [15:0] a);
    logic [15:0] e;
    e = exp_q.pop_front();
    `CHK(e, a)
  endtask
  always @(posedge clock_i) begin
    if (rd_seen) begin
      take(rdata_o);
    end
    rd_seen <= rd_i;
  end
  always @(got_e) begin
    take(got_v);
  end
  task automatic span(input int n);
    hc = '{default: 0};
    repeat (n) begin
      @(posedge clock_i);
      pwm_pin_i <= 1'($urandom);
      derate_i <= 4'($urandom);
      foreach (hc[i]) hc[i] += int'(sink_on_o[i]);
    end
  endtask
  task automatic period();
    @(posedge boost_clk_o);
    per = 0;
    fork
      @(posedge boost_clk_o);
      forever @(posedge clock_i) per++;
    join_any
    disable fork;
  endtask
  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock_i);
    fails++;
    report_and_stop();
  end
  initial begin
    void'($urandom(63945));
    stored_main_level_i = 12'($urandom);
    stored_range_i = 3'($urandom);
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    rd(MODE_CTRL_OFS, MODE_CTRL_RST);
    rd(BOOST_CTRL_OFS, BOOST_CTRL_RST);
    rd(THRESH_OFS, TRIM_RST);
    rd(RSET_OFS, RSET_RST);
    rd(MAIN_LEVEL_OFS, {4'h0, stored_main_level_i});
    rd(SCALE_TRIM_OFS, {13'h0, stored_range_i});
    rd(STRING2_LEVEL_OFS, 16'h0000);
    rd(STRING3_LEVEL_OFS, 16'h0000);
    rd(5'h1f, 16'h0000);
    wr(MAIN_LEVEL_OFS, 16'h0333);
    for (int r = 0; r < 8; r++) begin
      wr(SCALE_TRIM_OFS, 16'(r));
      rd(TARGET0_OFS, 16'(FS_MA[r] * 200));
    end
    // Every level is set before any brightness is lit
    wr(MODE_CTRL_OFS, 16'h000f);
    wr(STRING2_LEVEL_OFS, 16'h0033);
    wr(STRING3_LEVEL_OFS, 16'h0033);
    wr(STRING4_LEVEL_OFS, 16'h0033);
    rd(TARGET0_OFS + 5'h1, 16'h7530);
    wr(SCALE_TRIM_OFS, 16'h0001);
    wr(RSET_OFS, 16'h2ee0);
    wr(MODE_CTRL_OFS, 16'h001f);
    rd(TARGET0_OFS, 16'h2ee0);
    rd(TARGET0_OFS + 5'h1, 16'h2ee0);
    wr(MODE_CTRL_OFS, 16'h000f);
    wr(SCALE_TRIM_OFS, 16'h0002);
    wr(THRESH_OFS, 16'h7770);
    rd(TARGET0_OFS, 16'h299a);
    wr(THRESH_OFS, 16'h777f);
    rd(TARGET0_OFS, 16'h242c);
    wr(MAIN_BRT_OFS, 16'h8008);
    wr(STRING2_BRT_OFS, 16'h1000);
    wr(STRING3_BRT_OFS, 16'h0001);
    wr(STRING4_BRT_OFS, 16'h1fff);
    span(8200);
    span(8192);
    post(16'h1001, 16'(hc[0]));
    post(16'h1000, 16'(hc[1]));
    post(16'h0001, 16'(hc[2]));
    post(16'h1fff, 16'(hc[3]));
    wr(MODE_CTRL_OFS, 16'h002f);
    low_req <= 4'b0100;
    repeat (8) @(posedge clock_i);
    post(16'h0004, {12'h0, cluster_fault_o});
    high_req <= 4'b0001;
    repeat (8) @(posedge clock_i);
    post(16'h0005, {12'h0, cluster_fault_o});
    high_req <= 4'b0000;
    repeat (4) @(posedge clock_i);
    rd(STATUS_OFS, 16'h0045);
    repeat (2) @(posedge clock_i);
    post(16'h0004, {12'h0, cluster_fault_o});
    wr(MODE_CTRL_OFS, 16'h000f);
    low_req <= 4'b1111;
    repeat (8) @(posedge clock_i);
    post(16'h0000, {12'h0, cluster_fault_o});
    low_req <= 4'b0001;
    wr(BOOST_CTRL_OFS, 16'h0000);
    wr(BOOST_CTRL_OFS, 16'h0a06);
    repeat (200) @(posedge clock_i);
    post(16'h0006, {10'h0, boost_setpoint_o});
    wr(MODE_CTRL_OFS, 16'h0001);
    repeat (300) @(posedge clock_i);
    post(16'h0006, {10'h0, boost_setpoint_o});
    span(1024);
    post(16'h0200, 16'(hc[0]));
    low_req <= 4'b0010;
    for (int i = 0; i < 2000 && boost_setpoint_o === 6'h06; i++) @(posedge clock_i);
    post(16'h0007, {10'h0, boost_setpoint_o});
    // Boost off first so the setpoint clears to zero and ramps up to the fixed setting
    wr(BOOST_CTRL_OFS, 16'h0000);
    wr(BOOST_CTRL_OFS, 16'h0946);
    period();
    period();
    post(16'h000a, 16'(per));
    wr(BOOST_CTRL_OFS, 16'h0806);
    period();
    period();
    post(16'h0064, 16'(per));
    wr(BOOST_CTRL_OFS, 16'h0946);
    sync_half <= 16'h0258;
    repeat (100) @(posedge clock_i);
    period();
    post(16'h000c, 16'(per));
    sync_half <= 16'h0000;
    repeat (100) @(posedge clock_i);
    period();
    period();
    post(16'h000a, 16'(per));
    wr(BOOST_CTRL_OFS, 16'h0c06);
    lo = 200;
    hi = 0;
    repeat (60) begin
      period();
      lo = (per < lo) ? per : lo;
      hi = (per > hi) ? per : hi;
    end
    post(16'h0062, 16'(lo));
    post(16'h0066, 16'(hi));
    repeat (4) @(posedge clock_i);
    report_and_stop();
  end
endmodule
bind led_cluster_ctrl led_cluster_monitor mon_u (.clock_i(clock_i), .rst_i(rst_i),
  .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .head_high_i(head_high_i),
  .head_low_i(head_low_i), .sink_on_o(sink_on_o), .cluster_fault_o(cluster_fault_o),
  .boost_setpoint_o(boost_setpoint_o), .boost_clk_o(boost_clk_o));
